// ---- src/acu_clock_select.sv ----
// Conversion clock selection and gating as a tick generator.
// Assumes prescaler tick input is one sys_clk cycle wide.
module acu_clock_select (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_select,
  input wire logic prescaler_tick,
  input wire logic run,
  output logic conv_tick
);
  typedef struct packed {
    logic half;
    logic tick;
  } acu_clk_s;
  acu_clk_s st, next_st;

  always_comb begin
    next_st = st;
    next_st.half = run ? ~st.half : 1'b0;
    // Gated off unless a conversion runs
    if (!run) begin
      next_st.tick = 1'b0;
    end else if (clock_select) begin
      next_st.tick = st.half; // fosc/2
    end else begin
      next_st.tick = prescaler_tick; // fosc/(n+1)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign conv_tick = st.tick;
endmodule : acu_clock_select

// ---- src/acu_pkg.sv ----
// Constants shared by the converter control unit files.
// Assumes a 4-bit CPU data bus with 16-bit I/O addresses.
package acu_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [15:0] ADDR_CONV_CONTROL = 16'hFF68;
  localparam logic [15:0] ADDR_PIN_SELECT = 16'hFF69;
  localparam logic [15:0] ADDR_RESULT_LOW = 16'hFF6A;
  localparam logic [15:0] ADDR_RESULT_HIGH = 16'hFF6B;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hFFE7;
  localparam logic [15:0] ADDR_IRQ_FLAG = 16'hFFF7;
  // ==========================================================
  // Field positions in the control, enable and flag nibbles
  localparam int CHAN_LSB = 0;
  localparam int CLKSEL_BIT = 2;
  localparam int START_BIT = 3;
  localparam int FLAG_BIT = 0;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam logic [7:0] RESULT_ZERO = 8'h00;
  // ==========================================================
  // Timing
  localparam int CONV_FREQ_KHZ = 2500;
  localparam int MIN_CONV_TIME_NS = 8000;
  // Conversion clock periods for a whole conversion, rounded up
  localparam int MIN_CONV_CYCLES =
    (MIN_CONV_TIME_NS * CONV_FREQ_KHZ + 999999) / 1000000;
  localparam int RESULT_BITS = 8;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ACU_IDLE = 3'b000,
    ACU_DELAY = 3'b001,
    ACU_SAMPLE = 3'b010,
    ACU_DECIDE = 3'b011,
    ACU_STORE = 3'b100
  } acu_state_e;
endpackage : acu_pkg

// ---- src/acu_sar.sv ----
// Successive approximation register, MSB first.
// Assumes the comparator result is valid at each decide step.
module acu_sar #(
  parameter int BITS = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire logic comp_high,
  output logic [BITS-1:0] trial,
  output logic last
);
  typedef struct packed {
    logic [BITS-1:0] code;
    logic [BITS-1:0] mask;
  } acu_sar_s;
  acu_sar_s st, next_st;

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.code = {1'b1, {(BITS-1){1'b0}}};
      next_st.mask = {1'b1, {(BITS-1){1'b0}}};
    end else if (step) begin
      // Keep or drop current trial bit, try next lower
      if (!comp_high) begin
        next_st.code = st.code & ~st.mask;
      end
      next_st.mask = st.mask >> 1;
      next_st.code = next_st.code | next_st.mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign trial = st.code;
  assign last = st.mask[0];
endmodule : acu_sar

// ---- src/acu_top.sv ----
// Converter control unit: nibble registers, sequencer, pin steering.
// Assumes a synchronous 4-bit CPU I/O bus and external analog front end.
// ==========================================================
// Functional notes
// - Pin select bit high makes its shared pin an analog input.
// - Any combination of pin select bits may be set together.
// - Reset clears all pin select bits.
// - Clock select 0 takes prescaler, 1 takes oscillator over two.
// - Conversion clock reaches converter only after a start write.
// - Prescaler source runs at oscillator over divide setting plus one.
// - Channel field value 0 to 3 selects analog input 0 to 3.
// - Writing 1 to start begins conversion; writing 0 does nothing.
// - Start bit and unused flag and mask bits read as zero.
// - Sampling begins after one sample start delay.
// - Eight-bit successive approximation, most significant bit first.
// - Result low nibble at lower address, high nibble next.
// - Completion flag set right after result is stored.
// - Interrupt request when flag set and enable bit is 1.
// - Flag set on every conversion regardless of enable.
// - Writing 1 clears the flag; writing 0 leaves it.
// - Result not reset; control, enable and flag reset to 0.
// - Whole conversion at 2.5 MHz takes at least 8 us.
module acu_top #(
  parameter int SAMPLE_TICKS = 2,
  parameter int TICKS_PER_BIT = 2,
  parameter int DELAY_TICKS = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [3:0] io_wdata,
  output logic [3:0] io_rdata,
  input wire logic prescaler_tick,
  input wire logic comp_high,
  output logic [3:0] analog_pin_enable,
  output logic [1:0] channel_select,
  output logic sample_hold,
  output logic [7:0] dac_trial,
  output logic conv_busy,
  output logic irq_request
);
  localparam int CNT_W = 8;
  // Ensure the minimum conversion length in conversion clocks
  localparam int RAW_TICKS = DELAY_TICKS + SAMPLE_TICKS + acu_pkg::RESULT_BITS * TICKS_PER_BIT;
  localparam int PAD_TICKS = (RAW_TICKS < acu_pkg::MIN_CONV_CYCLES) ?
    acu_pkg::MIN_CONV_CYCLES - RAW_TICKS : 0;
  localparam logic [CNT_W-1:0] DELAY_END = CNT_W'(DELAY_TICKS + PAD_TICKS - 1);
  localparam logic [CNT_W-1:0] SAMPLE_END = CNT_W'(SAMPLE_TICKS - 1);
  localparam logic [CNT_W-1:0] BIT_END = CNT_W'(TICKS_PER_BIT - 1);

  typedef struct packed {
    acu_pkg::acu_state_e state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] chan;
    logic clk_sel;
    logic [3:0] pins;
    logic irq_en;
    logic flag;
    logic [7:0] result;
    logic [3:0] rdata;
    logic hold;
    logic busy;
    logic irq;
  } acu_top_s;
  acu_top_s st, next_st;

  logic conv_tick;
  logic [7:0] trial;
  logic sar_last;
  logic sar_clear;
  logic sar_step;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction : hit

  acu_clock_select u_clk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clock_select(st.clk_sel),
    .prescaler_tick(prescaler_tick),
    .run(st.busy),
    .conv_tick(conv_tick)
  );

  acu_sar #(.BITS(acu_pkg::RESULT_BITS)) u_sar (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(sar_clear),
    .step(sar_step),
    .comp_high(comp_high),
    .trial(trial),
    .last(sar_last)
  );

  // ==========================================================
  // Sequencer and registers
  always_comb begin
    logic start;
    logic done;
    next_st = st;
    sar_clear = 1'b0;
    sar_step = 1'b0;
    done = 1'b0;
    start = io_wr && hit(io_addr, acu_pkg::ADDR_CONV_CONTROL)
      && io_wdata[acu_pkg::START_BIT];

    if (io_wr && hit(io_addr, acu_pkg::ADDR_CONV_CONTROL)) begin
      next_st.chan = io_wdata[acu_pkg::CHAN_LSB +: 2];
      next_st.clk_sel = io_wdata[acu_pkg::CLKSEL_BIT];
    end
    if (io_wr && hit(io_addr, acu_pkg::ADDR_PIN_SELECT)) begin
      next_st.pins = io_wdata; // independent bits
    end
    if (io_wr && hit(io_addr, acu_pkg::ADDR_IRQ_ENABLE)) begin
      next_st.irq_en = io_wdata[acu_pkg::FLAG_BIT];
    end

    unique case (st.state)
      acu_pkg::ACU_IDLE: begin
        if (start) begin
          next_st.state = acu_pkg::ACU_DELAY;
          next_st.cnt = '0;
          next_st.busy = 1'b1;
        end
      end
      acu_pkg::ACU_DELAY: begin
        // Wait the sample start delay
        if (conv_tick) begin
          if (st.cnt == DELAY_END) begin
            next_st.state = acu_pkg::ACU_SAMPLE;
            next_st.cnt = '0;
            next_st.hold = 1'b1;
          end else begin
            next_st.cnt = st.cnt + 1'b1;
          end
        end
      end
      acu_pkg::ACU_SAMPLE: begin
        if (conv_tick) begin
          if (st.cnt == SAMPLE_END) begin
            next_st.state = acu_pkg::ACU_DECIDE;
            next_st.cnt = '0;
            next_st.hold = 1'b0;
            sar_clear = 1'b1;
          end else begin
            next_st.cnt = st.cnt + 1'b1;
          end
        end
      end
      acu_pkg::ACU_DECIDE: begin
        // One bit decided per TICKS_PER_BIT conversion clocks
        if (conv_tick) begin
          if (st.cnt == BIT_END) begin
            next_st.cnt = '0;
            if (sar_last) begin
              next_st.state = acu_pkg::ACU_STORE;
              next_st.result = {trial[acu_pkg::RESULT_BITS-1:1], comp_high};
            end else begin
              sar_step = 1'b1;
            end
          end else begin
            next_st.cnt = st.cnt + 1'b1;
          end
        end
      end
      acu_pkg::ACU_STORE: begin
        // Flag set the cycle after result stored
        done = 1'b1;
        next_st.state = acu_pkg::ACU_IDLE;
        next_st.busy = 1'b0;
      end
      default: begin
        next_st.state = acu_pkg::ACU_IDLE;
        next_st.busy = 1'b0;
      end
    endcase

    // Set wins over a simultaneous clear
    if (done) begin
      next_st.flag = 1'b1;
    end else if (io_wr && hit(io_addr, acu_pkg::ADDR_IRQ_FLAG)
                 && io_wdata[acu_pkg::FLAG_BIT]) begin
      next_st.flag = 1'b0;
    end
    next_st.irq = next_st.flag & next_st.irq_en;

    // Read mux, registered; start bit and unused bits read zero
    next_st.rdata = acu_pkg::NIBBLE_ZERO;
    if (io_rd) begin
      if (hit(io_addr, acu_pkg::ADDR_CONV_CONTROL)) begin
        next_st.rdata = {1'b0, st.clk_sel, st.chan};
      end else if (hit(io_addr, acu_pkg::ADDR_PIN_SELECT)) begin
        next_st.rdata = st.pins;
      end else if (hit(io_addr, acu_pkg::ADDR_RESULT_LOW)) begin
        next_st.rdata = st.result[3:0];
      end else if (hit(io_addr, acu_pkg::ADDR_RESULT_HIGH)) begin
        next_st.rdata = st.result[7:4];
      end else if (hit(io_addr, acu_pkg::ADDR_IRQ_ENABLE)) begin
        next_st.rdata = {3'b000, st.irq_en};
      end else if (hit(io_addr, acu_pkg::ADDR_IRQ_FLAG)) begin
        next_st.rdata = {3'b000, st.flag};
      end
    end
  end

  // Result kept across reset, so it is assigned outside the reset branch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st.state <= acu_pkg::ACU_IDLE;
      st.cnt <= '0;
      st.chan <= acu_pkg::CHAN_RESET;
      st.clk_sel <= 1'b0;
      st.pins <= acu_pkg::NIBBLE_ZERO;
      st.irq_en <= 1'b0;
      st.flag <= 1'b0;
      st.rdata <= acu_pkg::NIBBLE_ZERO;
      st.hold <= 1'b0;
      st.busy <= 1'b0;
      st.irq <= 1'b0;
    end else begin
      st.state <= next_st.state;
      st.cnt <= next_st.cnt;
      st.chan <= next_st.chan;
      st.clk_sel <= next_st.clk_sel;
      st.pins <= next_st.pins;
      st.irq_en <= next_st.irq_en;
      st.flag <= next_st.flag;
      st.rdata <= next_st.rdata;
      st.hold <= next_st.hold;
      st.busy <= next_st.busy;
      st.irq <= next_st.irq;
    end
    st.result <= next_st.result;
  end

  // ==========================================================
  // Outputs
  assign io_rdata = st.rdata;
  assign analog_pin_enable = st.pins;
  assign channel_select = st.chan;
  assign sample_hold = st.hold;
  assign dac_trial = trial;
  assign conv_busy = st.busy;
  assign irq_request = st.irq;
endmodule : acu_top

// ---- test/acu_analog_model.sv ----
// Behavioural sample-and-hold, multiplexer and comparator.
// Assumes levels holds one byte per analog input, input 0 lowest.
module acu_analog_model (
  input wire logic sys_clk,
  input wire logic [31:0] levels,
  input wire logic [1:0] channel_select,
  input wire logic sample_hold,
  input wire logic [7:0] dac_trial,
  output logic comp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held = 8'h00;
  always @(posedge sys_clk) begin
    if (sample_hold) held <= levels[channel_select*8 +: 8];
  end
  assign comp_high = held >= dac_trial;
endmodule : acu_analog_model

// ---- test/acu_chk.sv ----
// Checker for the converter control unit top ports.
// Assumes it is bound to acu_top and sees its ports only.
module acu_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [3:0] io_wdata,
  input wire logic [3:0] io_rdata,
  input wire logic [3:0] analog_pin_enable,
  input wire logic [1:0] channel_select,
  input wire logic sample_hold,
  input wire logic conv_busy,
  input wire logic irq_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] busy_cnt;
  // Busy length feeds the minimum conversion time check
  always_ff @(posedge sys_clk) begin
    busy_cnt <= (!rst_n || !conv_busy) ? 12'h000 : busy_cnt + 12'h001;
  end
  sequence s_start;
    io_wr && io_addr == 16'hFF68 && io_wdata[3];
  endsequence
  a_pin_write: assert property (io_wr && io_addr == 16'hFF69 |=>
    analog_pin_enable == $past(io_wdata)) else $error("pin select mismatch");
  a_chan_write: assert property (io_wr && io_addr == 16'hFF68 |=>
    channel_select == $past(io_wdata[1:0])) else $error("channel mismatch");
  a_busy_cause: assert property ($rose(conv_busy) |-> $past(io_wr && io_addr == 16'hFF68
    && io_wdata[3])) else $error("busy without start");
  a_start_busy: assert property (s_start ##1 !$past(conv_busy) |-> conv_busy)
    else $error("start not taken");
  a_sample_gap: assert property ($rose(conv_busy) |-> !sample_hold [*2])
    else $error("sampling too early");
  a_sample_gated: assert property (sample_hold |-> conv_busy)
    else $error("sampling while idle");
  a_min_time: assert property ($fell(conv_busy) |-> busy_cnt >= 12'h013)
    else $error("conversion too short");
  a_irq_cause: assert property ($rose(irq_request) |-> $fell(conv_busy)
    || $past(io_wr && io_addr == 16'hFFE7)) else $error("request without cause");
  a_irq_clear: assert property (io_wr && io_addr == 16'hFFF7 && io_wdata[0] && !conv_busy
    |=> !irq_request) else $error("flag not cleared");
  a_read_idle: assert property (!io_rd |=> io_rdata == 4'h0)
    else $error("read data not idle");
  a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> analog_pin_enable == 4'h0
    && !conv_busy && !irq_request) else $error("reset state wrong");
endmodule : acu_chk

// ---- test/test_adc_control_unit.sv ----
// Self-checking bench for the converter control unit.
// Assumes the analog model answers the comparator input.
module test_adc_control_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, io_wr = 0, io_rd = 0, ptick = 0, comp_high;
  logic [15:0] io_addr = 16'h0000;
  logic [3:0] io_wdata = 4'h0, io_rdata, pins;
  logic [1:0] chan;
  logic sh, busy, irq;
  logic [7:0] dac;
  logic [31:0] levels = 32'h0;
  int n_errors = 0, samples_checked = 0, cycles = 0, pdiv = 1, pcnt = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    pcnt = (pcnt >= pdiv) ? 0 : pcnt + 1;
    ptick <= (pcnt == 0);
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  acu_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .prescaler_tick(ptick),
    .comp_high(comp_high), .analog_pin_enable(pins), .channel_select(chan),
    .sample_hold(sh), .dac_trial(dac), .conv_busy(busy), .irq_request(irq));
  acu_analog_model model (.sys_clk(sys_clk), .levels(levels), .channel_select(chan),
    .sample_hold(sh), .dac_trial(dac), .comp_high(comp_high));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(negedge sys_clk);
    io_wr = 1; io_addr = a; io_wdata = d;
    @(negedge sys_clk);
    io_wr = 0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [3:0] exp);
    @(negedge sys_clk);
    io_rd = 1; io_addr = a;
    @(negedge sys_clk);
    io_rd = 0;
    chk($sformatf("read %h", a), {4'h0, exp}, {4'h0, io_rdata});
  endtask : rd
  task automatic t_reset;
    rd(16'hFF68, 4'h0);
    rd(16'hFF69, 4'h0);
    rd(16'hFFE7, 4'h0);
    rd(16'hFFF7, 4'h0);
    chk("pins", 8'h00, {4'h0, pins});
    $display("test reset done");
  endtask : t_reset
  task automatic t_pins;
    logic [3:0] v[3] = '{4'h5, 4'hA, 4'hF};
    foreach (v[i]) begin
      wr(16'hFF69, v[i]);
      chk("pins", {4'h0, v[i]}, {4'h0, pins});
      rd(16'hFF69, v[i]);
    end
    rd(16'hFF6C, 4'h0);
    $display("test pins done");
  endtask : t_pins
  // One conversion: clock source, channel, level, irq enable
  task automatic t_conv(input logic clk, input logic [1:0] ch, input logic [7:0] v,
      input logic en, input int div);
    int n;
    n = 0;
    pdiv = div;
    levels[ch*8 +: 8] = v;
    wr(16'hFFE7, {3'h0, en});
    wr(16'hFF68, {1'b0, clk, ch});
    chk("busy idle", 8'h00, {7'h0, busy});
    chk("channel", {6'h0, ch}, {6'h0, chan});
    wr(16'hFF68, {1'b1, clk, ch});
    wr(16'hFF68, {1'b1, clk, ch});
    while (busy === 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy done", 8'h00, {7'h0, busy});
    chk("last trial", {v[7:1], 1'b1}, dac);
    chk("long enough", 8'h01, {7'h0, n >= 20 * (clk ? 2 : div + 1) - 4});
    chk("irq", {7'h0, en}, {7'h0, irq});
    rd(16'hFF6A, v[3:0]);
    rd(16'hFF6B, v[7:4]);
    rd(16'hFFF7, 4'h1);
    rd(16'hFF68, {1'b0, clk, ch});
    wr(16'hFFF7, 4'h0);
    rd(16'hFFF7, 4'h1);
    wr(16'hFFF7, 4'h1);
    rd(16'hFFF7, 4'h0);
    chk("irq off", 8'h00, {7'h0, irq});
    $display("test conversion ch %0d done", ch);
  endtask : t_conv
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    t_reset();
    t_pins();
    t_conv(1'b1, 2'h1, 8'hA5, 1'b1, 1);
    t_conv(1'b0, 2'h3, 8'h3C, 1'b0, 3);
    t_conv(1'b1, 2'h0, 8'hFF, 1'b1, 1);
    t_conv(1'b0, 2'h2, 8'h00, 1'b0, 0);
    summarize();
  end
endmodule : test_adc_control_unit
bind acu_top acu_chk chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
  .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .analog_pin_enable(analog_pin_enable), .channel_select(channel_select),
  .sample_hold(sample_hold), .conv_busy(conv_busy), .irq_request(irq_request));
